// ### design/rft_stress_ram.sv
// one ram block with its stress lock logic
`timescale 1ns/1ps
module rft_stress_ram
(
	// clock and internal reset
	input  wire logic clock,
	input  wire logic rstInt_n,
	// config bus
	rft_cfg_if.ram    cfg
);
	typedef struct packed {
		logic       locked;
		logic       lastVld;
		logic [7:0] lastAdr;
		logic [7:0] lastDat;
		logic [7:0] lkAdr;
		logic [7:0] lkDat;
		logic [6:0] cnt;
	} rft_lock_s;

	rft_lock_s  s_r;
	rft_lock_s  s_nxt;
	logic [7:0] mem [256];
	logic       weHold;

	// lock entry on a repeated identical write with stress enabled
	always_comb
	begin
		s_nxt = s_r;
		if (!cfg.stressEn)
		begin
			s_nxt.locked = 1'b0;
			s_nxt.cnt    = '0;
		end
		else if (cfg.wrEn && !s_r.locked && s_r.lastVld &&
			cfg.addr == s_r.lastAdr && cfg.wdata == s_r.lastDat)
		begin
			s_nxt.locked = 1'b1;
			s_nxt.lkAdr  = cfg.addr;
			s_nxt.lkDat  = cfg.wdata;
		end
		if (cfg.wrEn && !s_r.locked)
		begin
			s_nxt.lastVld = 1'b1;
			s_nxt.lastAdr = cfg.addr;
			s_nxt.lastDat = cfg.wdata;
		end
		if (s_r.locked && s_r.cnt != rft_pkg::STRESS_CYC)
			s_nxt.cnt = s_r.cnt + 7'h01;
	end

	always_ff @(posedge clock or negedge rstInt_n)
	begin
		if (!rstInt_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// locked: write strobe held on the latched cell, bus writes ignored
	assign weHold = s_r.locked | cfg.wrEn;
	always_ff @(posedge clock)
	begin
		if (weHold)
			mem[s_r.locked ? s_r.lkAdr : cfg.addr] <= s_r.locked ? s_r.lkDat : cfg.wdata;
	end

	// source side keeps reading normally, byte wide
	assign cfg.rdata     = mem[cfg.addr];
	// no compare before the first write: an unwritten cell must not read as unknown
	assign cfg.match     = s_r.lastVld && (mem[cfg.addr] == s_r.lastDat);
	assign cfg.locked    = s_r.locked;
	assign cfg.stressMet = (s_r.cnt == rft_pkg::STRESS_CYC);
endmodule

// ### design/rft_test_top.sv
// test-mode hub: test select, ram stress, fifo fill and cache tests
`timescale 1ns/1ps
// How it works
// - repeat identical write under stress enters lock
// - lock latches data, address, holds write strobe
// - locked block ignores destination bus writes
// - dropping stress enable clears lock state
// - several ram blocks may lock together
// - byte ram read directly, compare status readable
// - scsi pin test set only when unlocked
// - scsi pin test may redefine scsi pins
// - scsi block keeps its own test register
// - quad fill copies byte into eight lanes
// - quad fill advances write pointer per write
// - data port reads return one byte
// - cache control test forces cache input zero
// - monitor test puts cache flags on pins
// - combined test forces and monitors together
// - internal reset async assert, sync release
// - always-driven tristate floats only in reset
// - select codes 02, 62, C2, E2 pick tests
// - straps low through reset unlock test bits
// - reset clears select except pad test
module rft_test_top
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// strap pins sampled around reset
	input  wire logic        trdyStrap_n,
	input  wire logic        devselStrap_n,
	input  wire logic        stopStrap_n,
	// cache logic, same clock
	input  wire logic [1:0]  cacheInNormal,
	input  wire logic        lineMatchFlagA,
	input  wire logic        lineMatchFlagB,
	input  wire logic        matchFlagA,
	input  wire logic        matchFlagB,
	input  wire logic        lineAdvance,
	input  wire logic        cacheStatus,
	input  wire logic        sequencerAccessFlag,
	input  wire logic        scsiAccessFlag,
	// test controls toward the chip
	output logic [1:0]       cacheLogicInput,
	output logic             fifoDirWrite,
	output logic             scsiPinTestEnable,
	output logic             fifoTestEnable,
	output logic             ramStressEnable,
	// scsi data pins
	output logic [7:0]       scsiDataOut,
	output logic             scsiDataOe,
	// unlock status pin
	output logic             unlockPinOut,
	output logic             unlockPinOe
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic        ack;
		logic [31:0] rdat;
		logic        postRst;
		logic        unlock;
		logic [1:0]  pendCnt;
		logic [7:0]  pendVal;
		logic [1:0]  fifoCtrl;
		logic [8:0]  ramAddr;
		logic [3:0]  wptr;
		logic [2:0]  wlane;
		logic [6:0]  rptr;
		logic [1:0]  cacheIn;
		logic [7:0]  scsi_data_pins;
		logic        scdOe;
		logic        pinOe;
	} rft_state_s;

	rft_state_s  s_r;
	rft_state_s  s_nxt;
	logic [7:0]  testSel_r;
	logic [7:0]  selNxt;
	logic        selLoad;
	logic        rstSync1_r;
	logic        rstSync2_r;
	logic        rstInt_n;
	logic        selRst_n;
	logic [2:0]  strap1_r;
	logic [2:0]  strap2_r;
	logic        strapLowHeld_r;
	logic [63:0] fifoMem [16];
	logic        fifoWr;
	logic        fifoQuad;
	logic [7:0]  fifoByte;
	logic        ramWr;
	logic [7:0]  ramRd [rft_pkg::RAM_BLOCKS];
	logic [rft_pkg::RAM_BLOCKS-1:0] ramLock;
	logic [rft_pkg::RAM_BLOCKS-1:0] ramMatch;
	logic [rft_pkg::RAM_BLOCKS-1:0] ramMet;
	logic        wbReq;
	logic        wbDo;
	logic        wbWr;
	logic        ctlSel;
	logic        monSel;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// pick one byte of a fifo word by lane
	function automatic logic [7:0] laneByte(input logic [63:0] w,
		input logic [2:0] lane);
		laneByte = w[{lane, 3'h0} +: 8];
	endfunction

	// ------------------------------------------------------------
	// reset synchroniser and strap capture
	// ------------------------------------------------------------
	// async assertion, release only on a clock edge
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end
		else
		begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end
	assign rstInt_n = rstSync2_r;

	// straps are pins: two flops, no reset so they run while held
	always_ff @(posedge clock)
	begin
		strap1_r <= {trdyStrap_n, devselStrap_n, stopStrap_n};
		strap2_r <= strap1_r;
		if (!rstInt_n)
			strapLowHeld_r <= (strap2_r == 3'h0);
	end

	// ------------------------------------------------------------
	// test select register
	// ------------------------------------------------------------
	// pad test survives host reset, so its reset is gated off
	assign selRst_n = rstInt_n | (testSel_r == rft_pkg::SEL_PAD);
	always_ff @(posedge clock or negedge selRst_n)
	begin
		if (!selRst_n)
			testSel_r <= rft_pkg::SEL_RST;
		else if (selLoad)
			testSel_r <= selNxt;
	end

	assign ctlSel = (testSel_r == rft_pkg::SEL_CCTL) ||
		(testSel_r == rft_pkg::SEL_CBOTH);
	assign monSel = (testSel_r == rft_pkg::SEL_CMON) ||
		(testSel_r == rft_pkg::SEL_CBOTH);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// ack one cycle after request; write acts on the ack edge
	assign wbReq = wb_cyc_i & wb_stb_i & ~s_r.ack;
	assign wbDo  = wb_cyc_i & wb_stb_i & s_r.ack;
	assign wbWr  = wbDo & wb_we_i & wb_sel_i[0];

	// quad fill only with the fifo test bit and select bits 7:5 zero
	assign fifoQuad = testSel_r[rft_pkg::SEL_FIFO] &&
		testSel_r[7:5] == rft_pkg::SEL_LOW0;
	assign fifoWr   = wbWr && wb_adr_i == rft_pkg::ADR_FDAT &&
		s_r.fifoCtrl[rft_pkg::FCTL_PORT];
	assign fifoByte = wb_dat_i[7:0];
	assign ramWr    = wbWr && wb_adr_i == rft_pkg::ADR_RDAT;

	// ------------------------------------------------------------
	// fifo storage
	// ------------------------------------------------------------
	// quad fill writes all eight lanes in one go
	always_ff @(posedge clock)
	begin
		if (fifoWr && fifoQuad)
			fifoMem[s_r.wptr] <= {8{fifoByte}};
		else if (fifoWr)
			fifoMem[s_r.wptr][{s_r.wlane, 3'h0} +: 8] <= fifoByte;
	end

	// ------------------------------------------------------------
	// ram blocks on the internal config bus
	// ------------------------------------------------------------
	// each block locks on its own, so several can stress at once
	generate
		for (genvar g = 0; g < rft_pkg::RAM_BLOCKS; g++)
		begin : gRam
			rft_cfg_if cfg ();
			assign cfg.wrEn     = ramWr && s_r.ramAddr[8] == 1'(g);
			assign cfg.addr     = s_r.ramAddr[7:0];
			assign cfg.wdata    = wb_dat_i[7:0];
			assign cfg.stressEn = testSel_r[rft_pkg::SEL_RAM];
			assign ramRd[g]     = cfg.rdata;
			assign ramLock[g]   = cfg.locked;
			assign ramMatch[g]  = cfg.match;
			assign ramMet[g]    = cfg.stressMet;
			rft_stress_ram uRam
			(
				.clock    (clock),
				.rstInt_n (rstInt_n),
				.cfg      (cfg.ram)
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt   = s_r;
		selLoad = 1'b0;
		selNxt  = s_r.pendVal;

		// first edge after release: straps must still be low
		s_nxt.postRst = 1'b0;
		if (s_r.postRst)
			s_nxt.unlock = strapLowHeld_r && strap2_r == 3'h0;

		// bus answer and read data
		s_nxt.ack = wbReq;
		if (wbReq && !wb_we_i)
		begin
			case (wb_adr_i)
				rft_pkg::ADR_SEL:  s_nxt.rdat = {24'h0, testSel_r};
				rft_pkg::ADR_STAT: s_nxt.rdat = {25'h0, ramMet, ramMatch,
					ramLock, s_r.unlock};
				rft_pkg::ADR_FCTL: s_nxt.rdat = {30'h0, s_r.fifoCtrl};
				rft_pkg::ADR_FDAT: s_nxt.rdat = {24'h0,
					laneByte(fifoMem[s_r.rptr[6:3]], s_r.rptr[2:0])};
				rft_pkg::ADR_RADR: s_nxt.rdat = {23'h0, s_r.ramAddr};
				rft_pkg::ADR_RDAT: s_nxt.rdat = {24'h0, ramRd[s_r.ramAddr[8]]};
				rft_pkg::ADR_FPTR: s_nxt.rdat = {17'h0, s_r.rptr, 1'b0,
					s_r.wptr, s_r.wlane};
				default:           s_nxt.rdat = 32'h0;
			endcase
		end

		// one byte per data port read
		if (wbDo && !wb_we_i && wb_adr_i == rft_pkg::ADR_FDAT)
			s_nxt.rptr = s_r.rptr + 7'h01;

		// delayed select load while unlocked
		if (s_r.pendCnt != 2'h0)
		begin
			s_nxt.pendCnt = s_r.pendCnt - 2'h1;
			selLoad       = (s_r.pendCnt == 2'h1);
		end

		// register writes
		if (wbWr)
		begin
			case (wb_adr_i)
				rft_pkg::ADR_SEL:
				begin
					// pin-redefining bits refused unless unlocked
					if (s_r.unlock)
					begin
						s_nxt.pendVal = wb_dat_i[7:0];
						s_nxt.pendCnt = rft_pkg::UNLOCK_DLY;
						selLoad       = 1'b0;
					end
					else
					begin
						selNxt  = wb_dat_i[7:0] & rft_pkg::SEL_LMASK;
						selLoad = 1'b1;
					end
				end
				rft_pkg::ADR_FCTL: s_nxt.fifoCtrl = wb_dat_i[1:0];
				rft_pkg::ADR_RADR: s_nxt.ramAddr  = wb_dat_i[8:0];
				rft_pkg::ADR_FPTR:
				begin
					s_nxt.wptr  = wb_dat_i[6:3];
					s_nxt.wlane = wb_dat_i[2:0];
					s_nxt.rptr  = wb_dat_i[14:8];
				end
				default: s_nxt.fifoCtrl = s_r.fifoCtrl;
			endcase
		end

		// write pointer: whole word in quad mode, else next byte
		if (fifoWr && fifoQuad)
		begin
			s_nxt.wptr  = s_r.wptr + 4'h1;
			s_nxt.wlane = 3'h0;
		end
		else if (fifoWr)
		begin
			s_nxt.wlane = s_r.wlane + 3'h1;
			if (s_r.wlane == 3'h7)
				s_nxt.wptr = s_r.wptr + 4'h1;
		end

		// cache input forced only while the control or combined test is selected
		s_nxt.cacheIn = ctlSel ? rft_pkg::CACHE_FRC : cacheInNormal;

		// cache outputs onto the scsi data pins
		s_nxt.scdOe = monSel;
		s_nxt.scsi_data_pins   = monSel ? {scsiAccessFlag, sequencerAccessFlag,
			cacheStatus, lineAdvance, matchFlagB, matchFlagA,
			lineMatchFlagB, lineMatchFlagA} : 8'h00;

		// driven from the first clock after reset on
		s_nxt.pinOe = 1'b1;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstInt_n)
	begin
		if (!rstInt_n)
		begin
			s_r          <= '0;
			s_r.postRst  <= 1'b1;
			s_r.fifoCtrl <= rft_pkg::FCTL_RST;
		end
		else
			s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// scsi block keeps its own test register; only the enable leaves here
	assign wb_dat_o          = s_r.rdat;
	assign wb_ack_o          = s_r.ack;
	assign cacheLogicInput   = s_r.cacheIn;
	assign fifoDirWrite      = s_r.fifoCtrl[rft_pkg::FCTL_DIR];
	assign scsiPinTestEnable = testSel_r[rft_pkg::SEL_SCSI];
	assign fifoTestEnable    = testSel_r[rft_pkg::SEL_FIFO];
	assign ramStressEnable   = testSel_r[rft_pkg::SEL_RAM];
	assign scsiDataOut       = s_r.scsi_data_pins;
	assign scsiDataOe        = s_r.scdOe;
	assign unlockPinOut      = s_r.unlock;
	assign unlockPinOe       = s_r.pinOe;
endmodule

// ### inc/rft_cfg_if.sv
// internal config bus between the test hub and one ram block
`timescale 1ns/1ps
interface rft_cfg_if;
	logic       wrEn;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       stressEn;
	logic [7:0] rdata;
	logic       locked;
	logic       match;
	logic       stressMet;

	modport hub (output wrEn, addr, wdata, stressEn,
		input rdata, locked, match, stressMet);
	modport ram (input wrEn, addr, wdata, stressEn,
		output rdata, locked, match, stressMet);
endinterface

// ### inc/rft_pkg.sv
// constants shared by the ram / fifo test-mode logic
package rft_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_SEL  = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_FCTL = 8'h08;
	localparam logic [7:0] ADR_FDAT = 8'h0C;
	localparam logic [7:0] ADR_RADR = 8'h10;
	localparam logic [7:0] ADR_RDAT = 8'h14;
	localparam logic [7:0] ADR_FPTR = 8'h18;

	// ------------------------------------------------------------
	// test select codes and bit positions
	// ------------------------------------------------------------
	localparam logic [7:0] SEL_RST   = 8'h00;
	localparam logic [7:0] SEL_QUAD  = 8'h02;
	localparam logic [7:0] SEL_CCTL  = 8'h62;
	localparam logic [7:0] SEL_CMON  = 8'hC2;
	localparam logic [7:0] SEL_CBOTH = 8'hE2;
	localparam logic [7:0] SEL_PAD   = 8'h29;
	localparam logic [7:0] SEL_LMASK = 8'hF6;
	localparam int         SEL_SCSI  = 0;
	localparam int         SEL_FIFO  = 1;
	localparam int         SEL_RAM   = 4;
	localparam logic [2:0] SEL_LOW0  = 3'h0;

	// ------------------------------------------------------------
	// fifo control fields
	// ------------------------------------------------------------
	localparam int         FCTL_PORT = 0;
	localparam int         FCTL_DIR  = 1;
	localparam logic [1:0] FCTL_RST  = 2'h0;
	localparam logic [1:0] CACHE_FRC = 2'h0;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam logic [1:0] UNLOCK_DLY = 2'h2;
	localparam int         STRESS_NS  = 500;
	localparam int         CLK_NS     = 10;
	localparam logic [6:0] STRESS_CYC = 7'((STRESS_NS + CLK_NS - 1) / CLK_NS);
	localparam int         RAM_BLOCKS = 2;
endpackage

// ### testbench/rft_strap_model.sv
// tester model that drives the three unlock strap pins around reset
`timescale 1ns/1ps
module rft_strap_model
(
	// clock and host reset
	input  wire logic clock,
	input  wire logic reset_n,
	// tester choice for the next reset
	input  wire logic wantUnlock,
	// strap pins, pulled up when released
	output logic      trdyStrap_n,
	output logic      devselStrap_n,
	output logic      stopStrap_n
);
	// -----------------------------------------
	// strap timing
	// -----------------------------------------
	logic [3:0] holdCnt_r;

	// clocks since reset release, saturating
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			holdCnt_r <= 4'h0;
		else if (holdCnt_r != 4'hF)
			holdCnt_r <= holdCnt_r + 4'h1;
	end

	// low through reset and six clocks past it; sync and release eat four
	assign trdyStrap_n   = ~(wantUnlock && (!reset_n || holdCnt_r < 4'h6));
	assign devselStrap_n = trdyStrap_n;
	assign stopStrap_n   = trdyStrap_n;
endmodule

// ### testbench/rft_test_asserts.sv
// concurrent checks on the test hub ports
`timescale 1ns/1ps
module rft_test_asserts
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// bus handshake
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	input  wire logic       wb_ack_o,
	// cache logic side
	input  wire logic [1:0] cacheInNormal,
	input  wire logic [1:0] cacheLogicInput,
	input  wire logic       lineMatchFlagA,
	input  wire logic       lineMatchFlagB,
	input  wire logic       matchFlagA,
	input  wire logic       matchFlagB,
	input  wire logic       lineAdvance,
	input  wire logic       cacheStatus,
	input  wire logic       sequencerAccessFlag,
	input  wire logic       scsiAccessFlag,
	// test outputs
	input  wire logic [7:0] scsiDataOut,
	input  wire logic       scsiDataOe,
	input  wire logic       scsiPinTestEnable,
	input  wire logic       unlockPinOut,
	input  wire logic       unlockPinOe
);
	// -----------------------------------------
	// checks
	// -----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	chk_ack_answer: assert property (unlockPinOe && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_scd_map: assert property (scsiDataOe && $past(scsiDataOe) |->
		scsiDataOut == $past({scsiAccessFlag, sequencerAccessFlag, cacheStatus, lineAdvance,
		matchFlagB, matchFlagA, lineMatchFlagB, lineMatchFlagA}))
		else $error("monitor pins out of order");
	chk_scd_idle: assert property (!scsiDataOe |-> scsiDataOut == 8'h00)
		else $error("scsi data driven outside monitor test");
	chk_cache_norm: assert property (cacheLogicInput != 2'h0 |->
		cacheLogicInput == $past(cacheInNormal))
		else $error("cache input not the normal value");
	chk_oe_release: assert property ($rose(reset_n) |->
		!unlockPinOe ##1 !unlockPinOe ##1 !unlockPinOe ##1 unlockPinOe)
		else $error("internal reset release timing wrong");
	chk_oe_hold: assert property (unlockPinOe |=> unlockPinOe)
		else $error("driven output floated outside reset");
	chk_scsi_unlock: assert property ($rose(scsiPinTestEnable) |-> unlockPinOut)
		else $error("scsi pin test set while locked");
endmodule

bind rft_test_top rft_test_asserts u_rft_test_asserts
(
	.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .cacheInNormal(cacheInNormal), .cacheLogicInput(cacheLogicInput),
	.lineMatchFlagA(lineMatchFlagA), .lineMatchFlagB(lineMatchFlagB),
	.matchFlagA(matchFlagA), .matchFlagB(matchFlagB), .lineAdvance(lineAdvance),
	.cacheStatus(cacheStatus), .sequencerAccessFlag(sequencerAccessFlag),
	.scsiAccessFlag(scsiAccessFlag), .scsiDataOut(scsiDataOut), .scsiDataOe(scsiDataOe),
	.scsiPinTestEnable(scsiPinTestEnable), .unlockPinOut(unlockPinOut),
	.unlockPinOe(unlockPinOe)
);

// ### testbench/testbench.sv
// self-checking bench for the ram and fifo test-mode hub
`timescale 1ns/1ps
module testbench;
	// -----------------------------------------
	// signals
	// -----------------------------------------
	logic        clock;
	logic        reset_n;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        trdyStrap_n;
	logic        devselStrap_n;
	logic        stopStrap_n;
	logic        wantUnlock;
	logic [1:0]  cacheInNormal;
	logic [1:0]  prevCache;
	logic [7:0]  flags;
	logic [7:0]  prevFlags;
	logic [1:0]  cacheLogicInput;
	logic        fifoDirWrite;
	logic        scsiPinTestEnable;
	logic        fifoTestEnable;
	logic        ramStressEnable;
	logic [7:0]  scsiDataOut;
	logic        scsiDataOe;
	logic        unlockPinOut;
	logic        unlockPinOe;
	logic [31:0] expQ[$];
	logic [7:0]  codes[5];
	integer      seed;
	int          n_fail;
	int          checks_done;

	rft_test_top u_rft_test_top
	(
		.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trdyStrap_n(trdyStrap_n),
		.devselStrap_n(devselStrap_n), .stopStrap_n(stopStrap_n),
		.cacheInNormal(cacheInNormal), .lineMatchFlagA(flags[0]), .lineMatchFlagB(flags[1]),
		.matchFlagA(flags[2]), .matchFlagB(flags[3]), .lineAdvance(flags[4]),
		.cacheStatus(flags[5]), .sequencerAccessFlag(flags[6]), .scsiAccessFlag(flags[7]),
		.cacheLogicInput(cacheLogicInput), .fifoDirWrite(fifoDirWrite),
		.scsiPinTestEnable(scsiPinTestEnable), .fifoTestEnable(fifoTestEnable),
		.ramStressEnable(ramStressEnable), .scsiDataOut(scsiDataOut), .scsiDataOe(scsiDataOe),
		.unlockPinOut(unlockPinOut), .unlockPinOe(unlockPinOe)
	);

	rft_strap_model u_rft_strap_model
	(
		.clock(clock), .reset_n(reset_n), .wantUnlock(wantUnlock), .trdyStrap_n(trdyStrap_n),
		.devselStrap_n(devselStrap_n), .stopStrap_n(stopStrap_n)
	);

	// -----------------------------------------
	// clock, random cache traffic, read monitor
	// -----------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// cache flags wander every cycle; the old value is what the hub registers
	always @(posedge clock)
	begin
		prevCache <= cacheInNormal;
		prevFlags <= flags;
		cacheInNormal <= 2'($random(seed));
		flags <= 8'($random(seed));
	end

	// each read answer is judged against the oldest note
	always @(posedge clock)
		if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i && expQ.size() > 0)
			chk(wb_dat_o, expQ.pop_front());

	// -----------------------------------------
	// tasks
	// -----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			n_fail++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one classic cycle; a read notes its expected data first
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		if (!we)
			expQ.push_back(dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= we ? dat : 32'h0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clock);
		if (n >= 20)
		begin
			n_fail++;
			report_and_stop();
		end
	endtask

	// look between edges once the select has settled
	task automatic look(input logic frc, input logic mon);
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk({30'h0, cacheLogicInput}, frc ? 32'h0 : {30'h0, prevCache});
		chk({31'h0, scsiDataOe}, {31'h0, mon});
		chk({24'h0, scsiDataOut}, mon ? {24'h0, prevFlags} : 32'h0);
		@(posedge clock);
	endtask

	// reset held ten clocks with the clock running
	task automatic doReset(input logic unlock);
		wantUnlock <= unlock;
		reset_n <= 1'b0;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
	endtask

	// -----------------------------------------
	// main sequence
	// -----------------------------------------
	initial
	begin
		seed = 23728;
		n_fail = 0;
		checks_done = 0;
		reset_n = 1'b0;
		wantUnlock = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		cacheInNormal = 2'h0;
		flags = 8'h00;
		codes = '{rft_pkg::SEL_CCTL, rft_pkg::SEL_CMON, rft_pkg::SEL_CBOTH, rft_pkg::SEL_QUAD,
			rft_pkg::SEL_RST};
		@(posedge clock);
		doReset(1'b0);
		// straps released: locked, protected bits dropped, unmapped reads zero
		bus(1'b0, rft_pkg::ADR_STAT, 32'h0);
		bus(1'b1, rft_pkg::ADR_SEL, 32'h09);
		bus(1'b0, rft_pkg::ADR_SEL, 32'h0);
		bus(1'b0, 8'h1C, 32'h0);
		bus(1'b1, rft_pkg::ADR_FCTL, 32'h3);
		chk({31'h0, fifoDirWrite}, 32'h1);
		// a write without the low byte lane is ignored
		wb_sel_i <= 4'hE;
		bus(1'b1, rft_pkg::ADR_FCTL, 32'h0);
		wb_sel_i <= 4'hF;
		bus(1'b0, rft_pkg::ADR_FCTL, 32'h3);
		// every fifo select code, ending back in normal operation
		foreach (codes[i])
		begin
			bus(1'b1, rft_pkg::ADR_SEL, {24'h0, codes[i]});
			chk({31'h0, fifoTestEnable}, {31'h0, codes[i][1]});
			look(codes[i][5], codes[i][7]);
		end
		// quad fill then byte reads, then one plain byte write
		bus(1'b1, rft_pkg::ADR_SEL, 32'h02);
		bus(1'b1, rft_pkg::ADR_FPTR, 32'h0);
		bus(1'b1, rft_pkg::ADR_FDAT, 32'hA5);
		bus(1'b1, rft_pkg::ADR_FDAT, 32'h3C);
		bus(1'b0, rft_pkg::ADR_FPTR, 32'h10);
		for (int i = 0; i < 9; i++)
			bus(1'b0, rft_pkg::ADR_FDAT, (i < 8) ? 32'hA5 : 32'h3C);
		bus(1'b1, rft_pkg::ADR_SEL, 32'h0);
		bus(1'b1, rft_pkg::ADR_FDAT, 32'h77);
		bus(1'b0, rft_pkg::ADR_FPTR, 32'h0911);
		// both blocks written, stress on, same writes again
		bus(1'b1, rft_pkg::ADR_RADR, 32'h005);
		bus(1'b1, rft_pkg::ADR_RDAT, 32'h5A);
		bus(1'b1, rft_pkg::ADR_RADR, 32'h105);
		bus(1'b1, rft_pkg::ADR_RDAT, 32'hC3);
		bus(1'b1, rft_pkg::ADR_SEL, 32'h10);
		chk({31'h0, ramStressEnable}, 32'h1);
		bus(1'b1, rft_pkg::ADR_RDAT, 32'hC3);
		bus(1'b1, rft_pkg::ADR_RADR, 32'h005);
		bus(1'b1, rft_pkg::ADR_RDAT, 32'h5A);
		bus(1'b0, rft_pkg::ADR_STAT, 32'h1E);
		repeat (60) @(posedge clock);
		bus(1'b0, rft_pkg::ADR_STAT, 32'h7E);
		bus(1'b1, rft_pkg::ADR_RDAT, 32'h11);
		bus(1'b0, rft_pkg::ADR_RDAT, 32'h5A);
		bus(1'b1, rft_pkg::ADR_SEL, 32'h0);
		bus(1'b1, rft_pkg::ADR_RDAT, 32'h11);
		bus(1'b0, rft_pkg::ADR_RDAT, 32'h11);
		// unlocking reset, then the pad test surviving a reset
		bus(1'b1, rft_pkg::ADR_SEL, 32'h02);
		doReset(1'b1);
		bus(1'b0, rft_pkg::ADR_SEL, 32'h0);
		bus(1'b0, rft_pkg::ADR_STAT, 32'h1);
		chk({31'h0, unlockPinOut}, 32'h1);
		bus(1'b1, rft_pkg::ADR_SEL, 32'h01);
		repeat (2) @(posedge clock);
		chk({31'h0, scsiPinTestEnable}, 32'h1);
		bus(1'b1, rft_pkg::ADR_SEL, {24'h0, rft_pkg::SEL_PAD});
		repeat (2) @(posedge clock);
		doReset(1'b0);
		bus(1'b0, rft_pkg::ADR_SEL, 32'h29);
		chk({31'h0, scsiPinTestEnable}, 32'h1);
		report_and_stop();
	end
endmodule
